/* ord_pkg.sv */
`default_nettype none
package ord_pkg;
    // ------------------------------------------------------------
    // register map (byte addresses)
    // ------------------------------------------------------------
    localparam logic [11:0] ORD_CTRL_ADDR = 12'h000;
    localparam logic [11:0] ORD_THRESH_ADDR = 12'h004;
    localparam logic [11:0] ORD_FS_A_ADDR = 12'h008;
    localparam logic [11:0] ORD_FS_B_ADDR = 12'h00c;
    localparam logic [11:0] ORD_STATUS_ADDR = 12'h010;
    localparam logic [11:0] ORD_MASK_ADDR = 12'h014;
    localparam logic [11:0] ORD_LIVE_ADDR = 12'h018;
    localparam logic [9:0] ORD_TRIM_FIRST_IDX = 10'h08a;
    localparam logic [9:0] ORD_TRIM_SECOND_IDX = 10'h095;
    localparam logic [11:0] ORD_TRIM_FIRST_ADDR = {ORD_TRIM_FIRST_IDX, 2'b00};
    localparam logic [11:0] ORD_TRIM_SECOND_ADDR = {ORD_TRIM_SECOND_IDX, 2'b00};
    // ------------------------------------------------------------
    // control and status field positions
    // ------------------------------------------------------------
    localparam int ORD_CTRL_PERIOD_LSB = 0;
    localparam int ORD_CTRL_DUAL_BIT = 3;
    localparam int ORD_CTRL_INSEL_BIT = 4;
    localparam int ORD_CTRL_BGCAL_BIT = 5;
    localparam int ORD_CTRL_FGCAL_BIT = 6;
    localparam int ORD_CTRL_DEC_LSB = 8;
    localparam int ORD_ST_FG_DONE_BIT = 4;
    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [2:0] ORD_PERIOD_RST = 3'h0;
    localparam logic [7:0] ORD_HIGH_THR_RST = 8'hff;
    localparam logic [7:0] ORD_LOW_THR_RST = 8'hff;
    localparam logic [15:0] ORD_FS_RST = 16'h0000;
    localparam logic [7:0] ORD_TRIM_RST = 8'h00;
    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int ORD_CLK_MHZ = 200;
    localparam int ORD_FG_CAL_NS = 5120;
    localparam int ORD_FG_CAL_CYCLES_I = ORD_FG_CAL_NS * ORD_CLK_MHZ / 1000;
    localparam logic [10:0] ORD_FG_CAL_CYCLES = ORD_FG_CAL_CYCLES_I[10:0];
    localparam logic [10:0] ORD_HOLD_BASE = 11'h008;
    localparam int ORD_MAG_DROP = 3;
    // ------------------------------------------------------------
    // decimation modes
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        ORD_DEC_NONE = 2'h0,
        ORD_DEC_REAL = 2'h1,
        ORD_DEC_CPLX = 2'h2
    } ord_dec_t;
endpackage
`default_nettype wire

/* ord_chan.sv */
`timescale 1ns/1ps
`default_nettype none
module ord_chan
    import ord_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [11:0] sample,
    input wire logic sample_valid,
    input wire logic [7:0] high_threshold,
    input wire logic [7:0] low_threshold,
    input wire logic [2:0] flag_period_select,
    input wire logic [1:0] dec_mode,
    input wire logic [15:0] dec_in,
    input wire logic dec_in_valid,
    input wire logic dec_in_is_q,
    output logic high_flag,
    output logic low_flag,
    output logic [15:0] dec_out,
    output logic dec_out_valid
);
    typedef struct packed {
        logic [10:0] cnt_hi;
        logic [10:0] cnt_lo;
        logic flag_hi;
        logic flag_lo;
        logic [8:0] win;
        logic acc_hi;
        logic acc_lo;
        logic emb_hi;
        logic emb_lo;
        logic odd;
        logic [15:0] out;
        logic out_valid;
    } ord_chan_st_t;

    ord_chan_st_t st_r, st_nxt;
    logic [10:0] mag;
    logic [7:0] mag8;
    logic hit_hi, hit_lo;
    logic [10:0] hold_len;
    logic [8:0] win_last;

    // ------------------------------------------------------------
    // magnitude and compare
    // ------------------------------------------------------------
    always_comb begin
        if (sample == 12'h800) begin
            mag = 11'h7ff;
        end else if (sample[11]) begin
            mag = 11'((~sample) + 12'h001);
        end else begin
            mag = sample[10:0];
        end
    end
    assign mag8 = mag[10:ORD_MAG_DROP];
    assign hit_hi = sample_valid && (mag8 >= high_threshold);
    assign hit_lo = sample_valid && (mag8 >= low_threshold);
    assign hold_len = ORD_HOLD_BASE << flag_period_select;
    // window length minus one, in samples
    assign win_last = (dec_mode == ORD_DEC_REAL) ?
        9'((10'h002 << flag_period_select) - 10'h001) :
        9'((10'h001 << flag_period_select) - 10'h001);

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        st_nxt = st_r;
        st_nxt.flag_hi = hit_hi || (st_r.cnt_hi != 11'h000);
        st_nxt.flag_lo = hit_lo || (st_r.cnt_lo != 11'h000);
        if (hit_hi) begin
            st_nxt.cnt_hi = hold_len - 11'h001;
        end else if (st_r.cnt_hi != 11'h000) begin
            st_nxt.cnt_hi = st_r.cnt_hi - 11'h001;
        end
        if (hit_lo) begin
            st_nxt.cnt_lo = hold_len - 11'h001;
        end else if (st_r.cnt_lo != 11'h000) begin
            st_nxt.cnt_lo = st_r.cnt_lo - 11'h001;
        end
        if (sample_valid) begin
            if (st_r.win >= win_last) begin
                st_nxt.emb_hi = st_r.acc_hi || hit_hi;
                st_nxt.emb_lo = st_r.acc_lo || hit_lo;
                st_nxt.acc_hi = 1'b0;
                st_nxt.acc_lo = 1'b0;
                st_nxt.win = 9'h000;
            end else begin
                st_nxt.acc_hi = st_r.acc_hi || hit_hi;
                st_nxt.acc_lo = st_r.acc_lo || hit_lo;
                st_nxt.win = st_r.win + 9'h001;
            end
        end
        st_nxt.out_valid = dec_in_valid;
        if (dec_in_valid) begin
            unique case (dec_mode)
                ORD_DEC_CPLX: begin
                    st_nxt.out = {dec_in[15:1], dec_in_is_q ? st_r.emb_lo : st_r.emb_hi};
                end
                ORD_DEC_REAL: begin
                    st_nxt.out = {dec_in[15:1], st_r.odd ? st_r.emb_lo : st_r.emb_hi};
                    st_nxt.odd = !st_r.odd;
                end
                default: begin
                    st_nxt.out = dec_in;
                end
            endcase
        end
        if (dec_mode != ORD_DEC_REAL) begin
            st_nxt.odd = 1'b0;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign high_flag = st_r.flag_hi;
    assign low_flag = st_r.flag_lo;
    assign dec_out = st_r.out;
    assign dec_out_valid = st_r.out_valid;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    logic [11:0] since_hi_r;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            since_hi_r <= 12'hfff;
        end else if (hit_hi) begin
            since_hi_r <= 12'h000;
        end else if (since_hi_r != 12'hfff) begin
            since_hi_r <= since_hi_r + 12'h001;
        end
    end

    property p_hi_hit;
        @(posedge clk) disable iff (!rst_n)
        sample_valid && (mag8 >= high_threshold) |=> high_flag;
    endproperty
    a_hi_hit: assert property (p_hi_hit) else $error("high flag missed");

    property p_extreme;
        @(posedge clk) disable iff (!rst_n)
        sample_valid && (sample == 12'h800 || sample == 12'h7ff) |=> high_flag && low_flag;
    endproperty
    a_extreme: assert property (p_extreme) else $error("full scale not flagged");

    property p_lo_hit;
        @(posedge clk) disable iff (!rst_n)
        sample_valid && (mag8 >= low_threshold) |=> low_flag;
    endproperty
    a_lo_hit: assert property (p_lo_hit) else $error("low flag missed");

    property p_hold;
        @(posedge clk) disable iff (!rst_n)
        $stable(flag_period_select) |->
            high_flag == ({1'b0, since_hi_r} < {1'b0, hold_len});
    endproperty
    a_hold: assert property (p_hold) else $error("hold length wrong");

    property p_cplx;
        @(posedge clk) disable iff (!rst_n)
        dec_in_valid && dec_mode == ORD_DEC_CPLX |=>
            dec_out == {$past(dec_in[15:1]),
                        $past(dec_in_is_q) ? $past(st_r.emb_lo) : $past(st_r.emb_hi)};
    endproperty
    a_cplx: assert property (p_cplx) else $error("complex embed wrong");

    property p_real;
        @(posedge clk) disable iff (!rst_n)
        dec_in_valid && dec_mode == ORD_DEC_REAL && !st_r.odd && !st_r.emb_hi |=>
            dec_out[0] == 1'b0 && st_r.odd;
    endproperty
    a_real: assert property (p_real) else $error("real embed wrong");

    c_hold: cover property (@(posedge clk) disable iff (!rst_n) $fell(high_flag));
    c_real: cover property (@(posedge clk) disable iff (!rst_n)
        dec_out_valid && dec_mode == ORD_DEC_REAL && dec_out[0]);
endmodule
`default_nettype wire

/* ord_top.sv */
// Local design decision: the APB register port.
`timescale 1ns/1ps
`default_nettype none
// Function
// - magnitude of 12-bit sample, upper eight bits compared to high and low thresholds
// - one threshold pair serves both channel A and channel B
// - most negative code counts as 2047, giving 255 at both extremes
// - flag is one when magnitude meets or exceeds threshold in the period
// - two flag pins per channel, first high threshold, second low threshold
// - pin flag holds 8 cycles at setting 0, doubling to 1024 at 7
// - decimating modes also embed flags into output samples
// - complex: I word LSB carries high flag, Q word LSB low flag
// - real: even samples carry high flag, odd samples low flag
// - embedded bit high when threshold met within the monitoring period
// - period is 2^(N+1) samples real, 2^N samples complex
// - single-channel input select bit chooses analog input A or B
// - separate full-scale trim setting for each analog input
// - offset trim registers at indices 0x08a and 0x095
// - foreground calibration stops sampling, background calibration keeps sampling
module ord_top
    import ord_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [11:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic irq,
    input wire logic [11:0] sample_a,
    input wire logic [11:0] sample_b,
    input wire logic sample_valid,
    output logic sampling_enable,
    output logic bg_cal_enable,
    output logic analog_input_sel,
    output logic [15:0] input_a_fullscale_trim,
    output logic [15:0] input_b_fullscale_trim,
    output logic [7:0] input_offset_trim_first,
    output logic [7:0] input_offset_trim_second,
    input wire logic [15:0] dec_a_in,
    input wire logic dec_a_in_valid,
    input wire logic dec_a_in_is_q,
    input wire logic [15:0] dec_b_in,
    input wire logic dec_b_in_valid,
    input wire logic dec_b_in_is_q,
    output logic [15:0] dec_a_out,
    output logic dec_a_out_valid,
    output logic [15:0] dec_b_out,
    output logic dec_b_out_valid,
    output logic chan_a_high_flag,
    output logic chan_a_low_flag,
    output logic chan_b_high_flag,
    output logic chan_b_low_flag
);
    typedef struct packed {
        logic [2:0] period;
        logic dual;
        logic insel;
        logic bgcal;
        logic [1:0] dec;
        logic [7:0] thr_hi;
        logic [7:0] thr_lo;
        logic [15:0] fs_a;
        logic [15:0] fs_b;
        logic [7:0] trim1;
        logic [7:0] trim2;
        logic [4:0] status;
        logic [4:0] mask;
        logic [3:0] prev;
        logic [10:0] fg_cnt;
        logic fg_busy;
        logic ack;
        logic err;
        logic [31:0] rdata;
    } ord_top_st_t;

    ord_top_st_t st_r, st_nxt;
    logic [3:0] flags;
    logic [1:0] dec_eff;
    logic gated_valid;
    logic acc_ph, wr_do, rd_do, mapped;
    logic [31:0] rd_mux;

    // ------------------------------------------------------------
    // channel datapaths
    // ------------------------------------------------------------
    assign gated_valid = sample_valid && !st_r.fg_busy;
    // decimation exists only in dual-channel operation
    assign dec_eff = st_r.dual ? st_r.dec : ORD_DEC_NONE;

    ord_chan u_chan_a (
        .clk(pclk),
        .rst_n(presetn),
        .sample(sample_a),
        .sample_valid(gated_valid),
        .high_threshold(st_r.thr_hi),
        .low_threshold(st_r.thr_lo),
        .flag_period_select(st_r.period),
        .dec_mode(dec_eff),
        .dec_in(dec_a_in),
        .dec_in_valid(dec_a_in_valid),
        .dec_in_is_q(dec_a_in_is_q),
        .high_flag(chan_a_high_flag),
        .low_flag(chan_a_low_flag),
        .dec_out(dec_a_out),
        .dec_out_valid(dec_a_out_valid)
    );

    ord_chan u_chan_b (
        .clk(pclk),
        .rst_n(presetn),
        .sample(sample_b),
        .sample_valid(gated_valid),
        .high_threshold(st_r.thr_hi),
        .low_threshold(st_r.thr_lo),
        .flag_period_select(st_r.period),
        .dec_mode(dec_eff),
        .dec_in(dec_b_in),
        .dec_in_valid(dec_b_in_valid),
        .dec_in_is_q(dec_b_in_is_q),
        .high_flag(chan_b_high_flag),
        .low_flag(chan_b_low_flag),
        .dec_out(dec_b_out),
        .dec_out_valid(dec_b_out_valid)
    );

    // single-channel: both cores feed the pins, outside logic ORs them
    assign flags = {chan_b_low_flag, chan_b_high_flag, chan_a_low_flag, chan_a_high_flag};

    // ------------------------------------------------------------
    // apb decode
    // ------------------------------------------------------------
    assign acc_ph = psel && penable;
    assign wr_do = acc_ph && st_r.ack && pwrite;
    assign rd_do = acc_ph && st_r.ack && !pwrite;

    always_comb begin
        mapped = 1'b1;
        rd_mux = 32'h0000_0000;
        unique case (paddr)
            ORD_CTRL_ADDR: begin
                rd_mux[ORD_CTRL_PERIOD_LSB +: 3] = st_r.period;
                rd_mux[ORD_CTRL_DUAL_BIT] = st_r.dual;
                rd_mux[ORD_CTRL_INSEL_BIT] = st_r.insel;
                rd_mux[ORD_CTRL_BGCAL_BIT] = st_r.bgcal;
                rd_mux[ORD_CTRL_FGCAL_BIT] = st_r.fg_busy;
                rd_mux[ORD_CTRL_DEC_LSB +: 2] = st_r.dec;
            end
            ORD_THRESH_ADDR: rd_mux[15:0] = {st_r.thr_lo, st_r.thr_hi};
            ORD_FS_A_ADDR: rd_mux[15:0] = st_r.fs_a;
            ORD_FS_B_ADDR: rd_mux[15:0] = st_r.fs_b;
            ORD_STATUS_ADDR: rd_mux[4:0] = st_r.status;
            ORD_MASK_ADDR: rd_mux[4:0] = st_r.mask;
            ORD_LIVE_ADDR: rd_mux[4:0] = {st_r.fg_busy, flags};
            ORD_TRIM_FIRST_ADDR: rd_mux[7:0] = st_r.trim1;
            ORD_TRIM_SECOND_ADDR: rd_mux[7:0] = st_r.trim2;
            default: mapped = 1'b0;
        endcase
    end

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        st_nxt = st_r;
        st_nxt.ack = acc_ph && !st_r.ack;
        if (acc_ph && !st_r.ack) begin
            st_nxt.rdata = pwrite ? 32'h0000_0000 : rd_mux;
            st_nxt.err = !mapped;
        end
        if (wr_do) begin
            unique case (paddr)
                ORD_CTRL_ADDR: begin
                    st_nxt.period = pwdata[ORD_CTRL_PERIOD_LSB +: 3];
                    st_nxt.dual = pwdata[ORD_CTRL_DUAL_BIT];
                    st_nxt.insel = pwdata[ORD_CTRL_INSEL_BIT];
                    st_nxt.bgcal = pwdata[ORD_CTRL_BGCAL_BIT];
                    st_nxt.dec = pwdata[ORD_CTRL_DEC_LSB +: 2];
                    if (pwdata[ORD_CTRL_FGCAL_BIT] && !st_r.fg_busy) begin
                        st_nxt.fg_busy = 1'b1;
                        st_nxt.fg_cnt = ORD_FG_CAL_CYCLES;
                    end
                end
                ORD_THRESH_ADDR: begin
                    st_nxt.thr_hi = pwdata[7:0];
                    st_nxt.thr_lo = pwdata[15:8];
                end
                ORD_FS_A_ADDR: st_nxt.fs_a = pwdata[15:0];
                ORD_FS_B_ADDR: st_nxt.fs_b = pwdata[15:0];
                ORD_MASK_ADDR: st_nxt.mask = pwdata[4:0];
                ORD_TRIM_FIRST_ADDR: st_nxt.trim1 = pwdata[7:0];
                ORD_TRIM_SECOND_ADDR: st_nxt.trim2 = pwdata[7:0];
                default: st_nxt.err = st_r.err;
            endcase
        end
        // read clears only the bits it returned, new events win
        if (rd_do && paddr == ORD_STATUS_ADDR) begin
            st_nxt.status = st_r.status & ~st_r.rdata[4:0];
        end
        st_nxt.prev = flags;
        st_nxt.status[3:0] = st_nxt.status[3:0] | (flags & ~st_r.prev);
        if (st_r.fg_busy) begin
            if (st_r.fg_cnt == 11'h001) begin
                st_nxt.fg_busy = 1'b0;
                st_nxt.status[ORD_ST_FG_DONE_BIT] = 1'b1;
            end
            st_nxt.fg_cnt = st_r.fg_cnt - 11'h001;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_r <= '0;
            st_r.period <= ORD_PERIOD_RST;
            st_r.thr_hi <= ORD_HIGH_THR_RST;
            st_r.thr_lo <= ORD_LOW_THR_RST;
            st_r.fs_a <= ORD_FS_RST;
            st_r.fs_b <= ORD_FS_RST;
            st_r.trim1 <= ORD_TRIM_RST;
            st_r.trim2 <= ORD_TRIM_RST;
        end else begin
            st_r <= st_nxt;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign prdata = st_r.rdata;
    assign pready = st_r.ack;
    assign pslverr = st_r.ack && st_r.err;
    assign irq = |(st_r.status & st_r.mask);
    assign sampling_enable = !st_r.fg_busy;
    assign bg_cal_enable = st_r.bgcal;
    assign analog_input_sel = st_r.insel;
    assign input_a_fullscale_trim = st_r.fs_a;
    assign input_b_fullscale_trim = st_r.fs_b;
    assign input_offset_trim_first = st_r.trim1;
    assign input_offset_trim_second = st_r.trim2;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    property p_fg_stop;
        @(posedge pclk) disable iff (!presetn)
        $rose(st_r.fg_busy) |-> (!sampling_enable)[*8];
    endproperty
    a_fg_stop: assert property (p_fg_stop) else $error("sampling not halted");

    property p_insel;
        @(posedge pclk) disable iff (!presetn)
        wr_do && paddr == ORD_CTRL_ADDR |=>
            analog_input_sel == $past(pwdata[ORD_CTRL_INSEL_BIT]);
    endproperty
    a_insel: assert property (p_insel) else $error("input select not applied");

    property p_thr_shared;
        @(posedge pclk) disable iff (!presetn)
        wr_do && paddr == ORD_THRESH_ADDR |=>
            st_r.thr_hi == $past(pwdata[7:0]) && st_r.thr_lo == $past(pwdata[15:8]);
    endproperty
    a_thr_shared: assert property (p_thr_shared) else $error("threshold write lost");

    c_fg: cover property (@(posedge pclk) disable iff (!presetn) $fell(st_r.fg_busy));
    c_irq: cover property (@(posedge pclk) disable iff (!presetn) $rose(irq));
    c_both: cover property (@(posedge pclk) disable iff (!presetn)
        chan_a_high_flag && chan_b_low_flag);
endmodule
`default_nettype wire

/* ord_far_model.sv */
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------------------------
// downstream logic: single-channel threshold merge
// ------------------------------------------------------------
module ord_far_model (
    input wire logic chan_a_high_flag,
    input wire logic chan_a_low_flag,
    input wire logic chan_b_high_flag,
    input wire logic chan_b_low_flag,
    output logic any_high,
    output logic any_low
);
    assign any_high = chan_a_high_flag | chan_b_high_flag;
    assign any_low = chan_a_low_flag | chan_b_low_flag;
endmodule
`default_nettype wire

/* ord_top_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module ord_top_tb
    import ord_pkg::*;
;
    // ------------------------------------------------------------
    // signals
    // ------------------------------------------------------------
    logic pclk, presetn, psel, penable, pwrite, sample_valid, pready, pslverr, irq, er;
    logic [11:0] paddr, sample_a, sample_b;
    logic [31:0] pwdata, prdata, rd;
    logic samp_en, bg_en, in_sel, any_high, any_low, ahf, alf, bhf, blf;
    logic [15:0] fs_a, fs_b, dai, dbi, dao, dbo;
    logic [7:0] tr1, tr2;
    logic dav, daq, dbv, dbq, daov, dbov;
    int bad_count, samples_checked, cnt;
    ord_top dut_u (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .irq(irq), .sample_a(sample_a),
        .sample_b(sample_b), .sample_valid(sample_valid), .sampling_enable(samp_en),
        .bg_cal_enable(bg_en), .analog_input_sel(in_sel), .input_a_fullscale_trim(fs_a),
        .input_b_fullscale_trim(fs_b), .input_offset_trim_first(tr1),
        .input_offset_trim_second(tr2), .dec_a_in(dai), .dec_a_in_valid(dav),
        .dec_a_in_is_q(daq), .dec_b_in(dbi), .dec_b_in_valid(dbv), .dec_b_in_is_q(dbq),
        .dec_a_out(dao), .dec_a_out_valid(daov), .dec_b_out(dbo), .dec_b_out_valid(dbov),
        .chan_a_high_flag(ahf), .chan_a_low_flag(alf), .chan_b_high_flag(bhf),
        .chan_b_low_flag(blf));
    ord_far_model far_u (.chan_a_high_flag(ahf), .chan_a_low_flag(alf),
        .chan_b_high_flag(bhf), .chan_b_low_flag(blf), .any_high(any_high),
        .any_low(any_low));
    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    task automatic close_out();
        $display("checks %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        samples_checked++;
        if (g !== e) begin
            bad_count++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        #1;
    endtask
    task automatic hit(input logic [11:0] a, input logic [11:0] b, input int n);
        @(posedge pclk);
        sample_a <= a;
        sample_b <= b;
        sample_valid <= 1'b1;
        repeat (n) @(posedge pclk);
        sample_valid <= 1'b0;
        #1;
    endtask
    task automatic word(input logic q, input logic [15:0] d, input logic [15:0] e);
        @(posedge pclk);
        dai <= d;
        dbi <= d;
        daq <= q;
        dbq <= q;
        dav <= 1'b1;
        dbv <= 1'b1;
        @(posedge pclk);
        dav <= 1'b0;
        dbv <= 1'b0;
        #1;
        chk("dec_a_out", {16'h0, e}, {16'h0, dao});
        chk("dec_b_out", {16'h0, e}, {16'h0, dbo});
        chk("dec_valid", 32'h1, {31'h0, daov & dbov});
    endtask
    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_regs();
        apb(0, ORD_THRESH_ADDR, 0);
        chk("thresh_rst", 32'h0000ffff, rd);
        apb(0, ORD_TRIM_FIRST_ADDR, 0);
        chk("trim1_rst", 32'h0, rd);
        apb(0, ORD_TRIM_SECOND_ADDR, 0);
        chk("trim2_rst", 32'h0, rd);
        apb(0, 12'h01c, 0);
        chk("unmapped_err", 32'h1, {31'h0, er});
        apb(1, ORD_TRIM_FIRST_ADDR, 32'h5a);
        apb(1, ORD_TRIM_SECOND_ADDR, 32'ha5);
        apb(1, ORD_FS_A_ADDR, 32'h1111);
        apb(1, ORD_FS_B_ADDR, 32'h2222);
        chk("trims", 32'h5aa5, {16'h0, tr1, tr2});
        chk("fs", 32'h11112222, {fs_a, fs_b});
        apb(0, ORD_TRIM_SECOND_ADDR, 0);
        chk("trim2_rd", 32'ha5, rd);
    endtask
    task automatic t_hold();
        apb(1, ORD_THRESH_ADDR, 32'h40fe);
        for (int p = 0; p < 8; p++) begin
            apb(1, ORD_CTRL_ADDR, 32'h8 | p);
            hit(12'h800, 12'h200, 1);
            chk("b_high", 32'h0, {31'h0, bhf});
            chk("b_low_equal", 32'h1, {31'h0, blf});
            chk("a_low", 32'h1, {31'h0, alf});
            chk("far_low", 32'h1, {31'h0, any_low});
            chk("far_high", 32'h1, {31'h0, any_high});
            cnt = 0;
            repeat (1100) begin
                if (ahf === 1'b1)
                    cnt++;
                @(posedge pclk);
                #1;
            end
            chk("hold_len", 32'h8 << p, cnt);
        end
    endtask
    task automatic t_irq();
        chk("irq_masked", 32'h0, {31'h0, irq});
        apb(1, ORD_MASK_ADDR, 32'hf);
        chk("irq_on", 32'h1, {31'h0, irq});
        apb(0, ORD_STATUS_ADDR, 0);
        chk("status", 32'hb, rd);
        @(posedge pclk);
        #1;
        chk("irq_off", 32'h0, {31'h0, irq});
    endtask
    task automatic t_fg();
        apb(1, ORD_CTRL_ADDR, 32'h70);
        @(posedge pclk);
        #1;
        chk("sampling_off", 32'h1, {30'h0, samp_en, bg_en});
        chk("input_sel", 32'h1, {31'h0, in_sel});
        apb(0, ORD_LIVE_ADDR, 0);
        chk("live_busy", 32'h10, rd);
        apb(0, ORD_CTRL_ADDR, 0);
        chk("ctrl_busy", 32'h70, rd);
        hit(12'h800, 12'h800, 1);
        repeat (2) @(posedge pclk);
        #1;
        chk("flag_refused", 32'h0, {31'h0, ahf | bhf});
        cnt = 0;
        while (samp_en !== 1'b1 && cnt < 1200) begin
            @(posedge pclk);
            #1;
            cnt++;
        end
        chk("sampling_back", 32'h1, {31'h0, samp_en});
        apb(0, ORD_STATUS_ADDR, 0);
        chk("fg_done", 32'h10, rd);
    endtask
    task automatic t_emb();
        apb(1, ORD_CTRL_ADDR, 32'h208);
        hit(12'h200, 12'h200, 4);
        word(1'b0, 16'haaaa, 16'haaaa);
        word(1'b1, 16'haaaa, 16'haaab);
        apb(1, ORD_CTRL_ADDR, 32'h108);
        hit(12'h200, 12'h200, 4);
        word(1'b0, 16'h5555, 16'h5554);
        word(1'b0, 16'h5555, 16'h5555);
    endtask
    initial begin
        pclk = 1'b0;
        forever #2.5 pclk = ~pclk;
    end
    initial begin
        #150000;
        bad_count++;
        close_out();
    end
    initial begin
        {presetn, psel, penable, pwrite, sample_valid, dav, dbv, daq, dbq} = '0;
        {paddr, sample_a, sample_b, pwdata, dai, dbi} = '0;
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        t_regs();
        t_hold();
        t_irq();
        t_fg();
        t_emb();
        close_out();
    end
endmodule
`default_nettype wire
